// File: rtc_bus_master.sv
// Two-wire bus master model facing the clock chip
`default_nettype none
module rtc_bus_master
  import rtc_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // Bus
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  // Eight clocks a phase, twice the slave's minimum
  localparam int HALF = 8;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Data moves while the clock line is low, except in the start and stop conditions
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    r = sda_line;
    scl <= 1'b0;
    wait_clk(HALF);
  endtask

  task automatic start();
    sda_pull <= 1'b1;
    wait_clk(HALF);
    scl <= 1'b0;
    wait_clk(HALF);
  endtask

  task automatic stop();
    sda_pull <= 1'b1;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    sda_pull <= 1'b0;
    wait_clk(HALF);
  endtask

  // MSB first, ninth bit is the acknowledge slot
  task automatic byte_io(input byte_t tx, input logic ninth, output byte_t rx, output logic ninth_r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ninth, ninth_r);
  endtask
endmodule // rtc_bus_master
`default_nettype wire

// File: rtc_pkg.sv
// Types shared by the clock modules
`default_nettype none
package rtc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b010,
    ST_PTR   = 3'b011,
    ST_WRITE = 3'b100,
    ST_WACK  = 3'b101,
    ST_READ  = 3'b110,
    ST_RACK  = 3'b111
  } bus_state_t;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// File: rtc_prescaler.sv
// Crystal prescaler: 32.768 kHz edges down to a one-second tick
`include "rtc_regs.svh"
`default_nettype none
module rtc_prescaler
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Crystal
  input  wire logic xtal_in,
  // Bank side
  rtc_tick_if.divider tk
);
  logic        xtal_q, xtal_d;
  logic [14:0] cnt_q, cnt_d;
  logic        tick_q, tick_d;

  always_comb begin
    xtal_d = xtal_in;
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (tk.run && xtal_in && !xtal_q) begin
      cnt_d  = cnt_q + 15'h0001;
      // Test mode skips division so a second passes per crystal edge
      tick_d = tk.fast || (cnt_q == `PRESC_LAST);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xtal_q <= 1'b0;
      cnt_q  <= 15'h0000;
      tick_q <= 1'b0;
    end else begin
      xtal_q <= xtal_d;
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tk.sec_tick  = tick_q;
  assign tk.presc     = cnt_q;
  assign tk.xtal_edge = xtal_q;
endmodule // rtc_prescaler
`default_nettype wire

// File: rtc_register_setup.sv
// Serial-bus real-time clock: bus slave, register bank, calendar, alarm, timer
//
// Function
// R1 - Oscillator test bit must be clear for the crystal oscillator to run.
// R2 - Halt field zero lets the crystal clock advance the time counters.
// R3 - Power-on test field cleared gives normal, non-test operation.
// R4 - Alarm interrupt enable zero keeps alarm match off the interrupt output.
// R5 - Timer interrupt enable zero keeps timer expiry off the interrupt output.
// R6 - Month bit 7 is century flag: one means 19xx, zero 20xx.
// R7 - Weekday counts 0 Sunday to 6 Saturday, wrapping at day rollover.
// R8 - Answer bus address 1010001; direction bit zero writes, one reads.
// R9 - First byte after address in a write loads the register pointer.
// R10 - Reads return data from the pointer; master NACK ends the read.
// R11 - Alarm bit 7 zero compares that field, one excludes it.
`include "rtc_regs.svh"
`default_nettype none
module rtc_register_setup
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Two-wire bus
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var  logic sda_out,
  output var  logic sda_oe,
  // Crystal and outputs
  input  wire logic xtal_in,
  output var  logic irq_n,
  output var  logic divided_clock_output
);
  rtc_tick_if tk ();
  rtc_prescaler u_presc (.ref_clk(ref_clk), .rst(rst), .xtal_in(xtal_in), .tk(tk));

  function automatic byte_t bcd_next(input byte_t v, input byte_t lo, input byte_t hi);
    if (v >= hi)
      return lo;
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic byte_t month_end(input byte_t m, input byte_t y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    unique case (m[4:0])
      5'h02:                      month_end = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_end = 8'h30;
      default:                    month_end = 8'h31;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // Bus line conditioning
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_p_q, sda_p_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire scl_rise = scl && !scl_p_q;
  wire scl_fall = !scl && scl_p_q;
  wire start_c  = scl && scl_p_q && !sda && sda_p_q;
  wire stop_c   = scl && scl_p_q && sda && !sda_p_q;

  ////////////////////////////////////////////////////////////////
  // Bus slave
  bus_state_t st_q, st_d;
  byte_t      sh_q, sh_d, rf_q [16], rf_d [16];
  logic [3:0] bit_q, bit_d, ptr_q, ptr_d;
  logic       oe_q, oe_d, rw_q, rw_d, nack_q, nack_d, wr_en;
  logic       irq_n_q, irq_n_d, clk_q, clk_d, amatch_q, amatch_d;

  always_comb begin
    st_d = st_q; sh_d = sh_q; bit_d = bit_q; ptr_d = ptr_q;
    oe_d = oe_q; rw_d = rw_q; nack_d = nack_q; wr_en = 1'b0;
    if (start_c) begin
      st_d = ST_ADDR; bit_d = 4'h0; oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = ST_IDLE; oe_d = 1'b0;
    end else if (scl_rise) begin
      unique case (st_q)
        ST_ADDR, ST_PTR, ST_WRITE: begin
          sh_d = {sh_q[6:0], sda}; bit_d = bit_q + 4'h1;
        end
        ST_READ: bit_d = bit_q + 4'h1;
        ST_RACK: nack_d = sda;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (st_q)
        ST_ADDR: if (bit_q == `BYTE_BITS) begin
          if (sh_q[7:1] == `DEV_ADDR) begin // [R8]
            st_d = ST_AACK; oe_d = 1'b1; rw_d = sh_q[0];
          end else
            st_d = ST_IDLE;
        end
        ST_AACK: begin
          bit_d = 4'h0;
          if (rw_q) begin // [R10]
            st_d = ST_READ; sh_d = rf_q[ptr_q]; oe_d = !rf_q[ptr_q][7];
          end else begin
            st_d = ST_PTR; oe_d = 1'b0;
          end
        end
        ST_PTR, ST_WRITE: if (bit_q == `BYTE_BITS) begin
          st_d = ST_WACK; oe_d = 1'b1;
          if (st_q == ST_PTR)
            ptr_d = sh_q[3:0]; // [R9]
          else begin
            wr_en = 1'b1; ptr_d = ptr_q + 4'h1;
          end
        end
        ST_WACK: begin
          st_d = ST_WRITE; oe_d = 1'b0; bit_d = 4'h0;
        end
        ST_READ: if (bit_q == `BYTE_BITS) begin
          st_d = ST_RACK; oe_d = 1'b0; ptr_d = ptr_q + 4'h1;
        end else begin
          sh_d = {sh_q[6:0], 1'b0}; oe_d = !sh_q[6];
        end
        ST_RACK: begin // [R10]
          bit_d = 4'h0;
          if (nack_q)
            st_d = ST_IDLE;
          else begin
            st_d = ST_READ; sh_d = rf_q[ptr_q]; oe_d = !rf_q[ptr_q][7];
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Calendar, alarm, timer
  wire byte_t cs1 = rf_q[`REG_CS1];
  wire byte_t cs2 = rf_q[`REG_CS2];
  assign tk.run  = !cs1[`CS1_OSC_TEST] && !cs1[`CS1_HALT]; // [R1] [R2]
  assign tk.fast = cs1[`CS1_FAST_TEST]; // [R3]
  wire   tick     = tk.sec_tick && tk.run;
  wire   min_roll = tick && rf_q[`REG_SEC] == `SEC_LAST;
  wire   hr_roll  = min_roll && rf_q[`REG_MIN] == `SEC_LAST;
  wire   day_roll = hr_roll && rf_q[`REG_HOUR] == `HOUR_LAST;
  wire   mon_roll = day_roll && rf_q[`REG_DAY] == month_end(rf_q[`REG_MONTH], rf_q[`REG_YEAR]);
  wire   yr_roll  = mon_roll && {3'b000, rf_q[`REG_MONTH][4:0]} == `MONTH_LAST;
  wire   yr_wrap  = yr_roll && rf_q[`REG_YEAR] == `YEAR_LAST;
  wire byte_t mon_next = bcd_next({3'b000, rf_q[`REG_MONTH][4:0]}, `FIRST_BYTE, `MONTH_LAST);

  // Disabled fields always match; all four disabled never match
  logic fld_ok [4];
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_alarm
    assign fld_ok[gi] = rf_q[`REG_AMIN + 4'(gi)][`ALARM_DIS] || // [R11]
                        rf_q[`REG_AMIN + 4'(gi)][6:0] == rf_q[`REG_MIN + 4'(gi)][6:0];
  end
  wire any_en = !(rf_q[`REG_AMIN][`ALARM_DIS] && rf_q[`REG_AHOUR][`ALARM_DIS]
                  && rf_q[`REG_ADAY][`ALARM_DIS] && rf_q[`REG_AWDAY][`ALARM_DIS]);

  always_comb begin
    rf_d = rf_q;
    amatch_d = any_en && fld_ok[0] && fld_ok[1] && fld_ok[2] && fld_ok[3];
    if (tick) begin
      rf_d[`REG_SEC] = bcd_next(rf_q[`REG_SEC], `ZERO_BYTE, `SEC_LAST);
      if (min_roll) rf_d[`REG_MIN] = bcd_next(rf_q[`REG_MIN], `ZERO_BYTE, `SEC_LAST);
      if (hr_roll) rf_d[`REG_HOUR] = bcd_next(rf_q[`REG_HOUR], `ZERO_BYTE, `HOUR_LAST);
      if (day_roll) begin
        rf_d[`REG_DAY]  = bcd_next(rf_q[`REG_DAY], `FIRST_BYTE, month_end(rf_q[`REG_MONTH], rf_q[`REG_YEAR]));
        rf_d[`REG_WDAY] = bcd_next(rf_q[`REG_WDAY], `ZERO_BYTE, `WDAY_LAST); // [R7]
      end
      if (mon_roll)
        rf_d[`REG_MONTH] = {rf_q[`REG_MONTH][`CENTURY] ^ yr_wrap, mon_next[6:0]}; // [R6]
      if (yr_roll) rf_d[`REG_YEAR] = bcd_next(rf_q[`REG_YEAR], `ZERO_BYTE, `YEAR_LAST);
      if (rf_q[`REG_TCTL][`TCTL_EN] && rf_q[`REG_TVAL] != `ZERO_BYTE) begin
        rf_d[`REG_TVAL] = rf_q[`REG_TVAL] - 8'h01;
      end
    end
    if (wr_en)
      rf_d[ptr_q] = sh_q;
    // Flag sets win over a bus clear in the same cycle
    if (amatch_d && !amatch_q) rf_d[`REG_CS2][`CS2_AF] = 1'b1;
    if (tick && rf_q[`REG_TCTL][`TCTL_EN] && rf_q[`REG_TVAL] == 8'h01) rf_d[`REG_CS2][`CS2_TF] = 1'b1;
    irq_n_d = !((cs2[`CS2_ALM_IRQ_EN] && cs2[`CS2_AF]) || (cs2[`CS2_CNT_IRQ_EN] && cs2[`CS2_TF])); // [R4] [R5]
    unique case (rf_q[`REG_DIVCLK][`DIVCLK_SEL])
      2'b00: clk_d = tk.xtal_edge;
      2'b01: clk_d = tk.presc[`DIV_TAP_32];
      2'b10: clk_d = tk.presc[`DIV_TAP_1K];
      2'b11: clk_d = tk.presc[`DIV_TAP_32K];
    endcase
    clk_d = clk_d && rf_q[`REG_DIVCLK][`DIVCLK_EN];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= ST_IDLE; sh_q <= `ZERO_BYTE; bit_q <= 4'h0; ptr_q <= 4'h0;
      oe_q <= 1'b0; rw_q <= 1'b0; nack_q <= 1'b1;
      for (int i = 0; i < 16; i++) rf_q[i] <= `RESET_BYTE;
      // Match starts high: all-zero registers already match, so no flag right after reset
      irq_n_q <= 1'b1; clk_q <= 1'b0; amatch_q <= 1'b1;
    end else begin
      st_q <= st_d; sh_q <= sh_d; bit_q <= bit_d; ptr_q <= ptr_d;
      oe_q <= oe_d; rw_q <= rw_d; nack_q <= nack_d;
      rf_q <= rf_d;
      irq_n_q <= irq_n_d; clk_q <= clk_d; amatch_q <= amatch_d;
    end
  end

  always_ff @(posedge ref_clk) sda_out <= 1'b0;
  assign sda_oe = oe_q;
  assign irq_n = irq_n_q;
  assign divided_clock_output = clk_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence addr_hit;
    st_q == ST_ADDR && scl_fall && !start_c && !stop_c && bit_q == `BYTE_BITS && sh_q[7:1] == `DEV_ADDR;
  endsequence
  sequence ptr_done;
    st_q == ST_PTR && scl_fall && !start_c && !stop_c && bit_q == `BYTE_BITS;
  endsequence
  AST_ADDR_ACK: assert property (addr_hit |=> oe_q && st_q == ST_AACK && rw_q == $past(sh_q[0])) // [R8]
    else $error("own address not acknowledged");
  AST_ADDR_MISS: assert property (st_q == ST_ADDR && scl_fall && !start_c && !stop_c && bit_q == `BYTE_BITS
      && sh_q[7:1] != `DEV_ADDR |=> !oe_q && st_q == ST_IDLE) // [R8]
    else $error("foreign address answered");
  AST_PTR_LOAD: assert property (ptr_done |=> ptr_q == $past(sh_q[3:0]) && oe_q) // [R9]
    else $error("pointer not loaded");
  AST_READ_END: assert property (st_q == ST_RACK && scl_fall && !start_c && !stop_c && nack_q
      |=> st_q == ST_IDLE ##1 !oe_q) // [R10]
    else $error("read not ended by nack");
  AST_ALARM_MASK: assert property (!cs2[`CS2_ALM_IRQ_EN] && !(cs2[`CS2_CNT_IRQ_EN] && cs2[`CS2_TF]) // [R4]
      |=> irq_n_q)
    else $error("alarm drove interrupt while disabled");
  AST_TIMER_MASK: assert property (!cs2[`CS2_CNT_IRQ_EN] && !(cs2[`CS2_ALM_IRQ_EN] && cs2[`CS2_AF]) // [R5]
      |=> irq_n_q)
    else $error("timer drove interrupt while disabled");
  AST_HALT: assert property (cs1[`CS1_HALT] && !wr_en |=> $stable(rf_q[`REG_SEC])) // [R2]
    else $error("seconds advanced while halted");
  AST_OSC_TEST: assert property (cs1[`CS1_OSC_TEST] && !wr_en |=> $stable(rf_q[`REG_SEC])) // [R1]
    else $error("seconds advanced with oscillator test set");
  AST_NORMAL: assert property (!$past(cs1[`CS1_FAST_TEST]) && $past(tk.presc) != `PRESC_LAST |-> !tk.sec_tick) // [R3]
    else $error("second tick before full division in normal mode");
  AST_CENTURY: assert property (yr_wrap && !wr_en |=> rf_q[`REG_MONTH][7] != $past(rf_q[`REG_MONTH][7])) // [R6]
    else $error("century flag not toggled");
  AST_WEEKDAY: assert property (day_roll && !wr_en && rf_q[`REG_WDAY] == `WDAY_LAST |=> rf_q[`REG_WDAY] == `ZERO_BYTE) // [R7]
    else $error("weekday did not wrap to sunday");
  AST_ALARM_FIELD: assert property (!rf_q[`REG_AMIN][7] && rf_q[`REG_AMIN][6:0] != rf_q[`REG_MIN][6:0]
      |=> !amatch_q) // [R11]
    else $error("enabled alarm field ignored");
endmodule // rtc_register_setup
`default_nettype wire

// File: rtc_regs.svh
// Register offsets, field positions and constants of the serial real-time clock
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
`define DEV_ADDR        7'h51
`define REG_CS1         4'h0
`define REG_CS2         4'h1
`define REG_SEC         4'h2
`define REG_MIN         4'h3
`define REG_HOUR        4'h4
`define REG_DAY         4'h5
`define REG_WDAY        4'h6
`define REG_MONTH       4'h7
`define REG_YEAR        4'h8
`define REG_AMIN        4'h9
`define REG_AHOUR       4'hA
`define REG_ADAY        4'hB
`define REG_AWDAY       4'hC
`define REG_DIVCLK      4'hD
`define REG_TCTL        4'hE
`define REG_TVAL        4'hF
`define CS1_OSC_TEST    7
`define CS1_HALT        5
`define CS1_FAST_TEST   3
`define CS2_AF          3
`define CS2_TF          2
`define CS2_ALM_IRQ_EN  1
`define CS2_CNT_IRQ_EN  0
`define ALARM_DIS       7
`define CENTURY         7
`define DIVCLK_EN       7
`define DIVCLK_SEL      1:0
`define DIV_TAP_32      4
`define DIV_TAP_1K      9
`define DIV_TAP_32K     14
`define TCTL_EN         7
`define BYTE_BITS       4'h8
`define PRESC_LAST      15'h7FFF
`define WDAY_LAST       8'h06
`define SEC_LAST        8'h59
`define HOUR_LAST       8'h23
`define MONTH_LAST      8'h12
`define YEAR_LAST       8'h99
`define FIRST_BYTE      8'h01
`define ZERO_BYTE       8'h00
`define RESET_BYTE      8'h00
`endif

// File: rtc_tick_if.sv
// Carrier between the register bank and the crystal prescaler
`default_nettype none
interface rtc_tick_if;
  logic        run;
  logic        fast;
  logic        sec_tick;
  logic [14:0] presc;
  logic        xtal_edge;
  modport bank  (output run, output fast, input sec_tick, input presc, input xtal_edge);
  modport divider (input run, input fast, output sec_tick, output presc, output xtal_edge);
endinterface
`default_nettype wire

// File: tb_rtc_register_setup.sv
// Self-checking bench for the serial real-time clock
`include "rtc_regs.svh"
`default_nettype none
module tb_rtc_register_setup
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic rst;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  logic xtal_in;
  logic irq_n;
  logic div_out;
  wire logic sda_line;
  int   fail_count;
  int   total_checks;

  // Open drain with pull-up
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));

  rtc_register_setup u_dut (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .xtal_in(xtal_in), .irq_n(irq_n), .divided_clock_output(div_out));
  rtc_bus_master u_bus (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input byte_t got, input byte_t exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic sendb(input byte_t v);
    byte_t r;
    logic  a;
    u_bus.byte_io(v, 1'b1, r, a);
    chk({7'h00, a}, 8'h00, "missing ack");
  endtask

  task automatic wr(input byte_t ptr, input byte_t d);
    u_bus.start();
    sendb({`DEV_ADDR, 1'b0});
    sendb(ptr);
    sendb(d);
    u_bus.stop();
  endtask

  task automatic rd(input byte_t ptr, input byte_t exp);
    byte_t r;
    logic  a;
    u_bus.start();
    sendb({`DEV_ADDR, 1'b0});
    sendb(ptr);
    u_bus.stop();
    u_bus.start();
    sendb({`DEV_ADDR, 1'b1});
    u_bus.byte_io(8'hFF, 1'b1, r, a);
    u_bus.stop();
    chk(r, exp, "read data");
  endtask

  // Crystal edges, far slower than the system clock
  task automatic xtal(input int n);
    repeat (n) begin
      xtal_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      xtal_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask

  initial begin
    repeat (80000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    byte_t r;
    logic  a;
    fail_count = 0;
    total_checks = 0;
    rst = 1'b1;
    xtal_in = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({7'h00, irq_n}, 8'h01, "irq after reset");
    chk({7'h00, div_out}, 8'h00, "clock out after reset");
    chk({7'h00, sda_out}, 8'h00, "data drive after reset");
    // Burst read from the reset pointer, NACK on the last byte
    u_bus.start();
    sendb({`DEV_ADDR, 1'b1});
    for (int i = 0; i < 16; i++) begin
      u_bus.byte_io(8'hFF, (i == 15), r, a);
      chk(r, `RESET_BYTE, "reset value");
    end
    u_bus.stop();
    // Foreign address must stay unanswered
    u_bus.start();
    u_bus.byte_io({7'h52, 1'b0}, 1'b1, r, a);
    chk({7'h00, a}, 8'h01, "foreign address acked");
    u_bus.stop();
    // Normal mode: one crystal edge is far from a second; test mode ticks per edge, halt and oscillator test stop it
    wr(`REG_CS1, 8'h00);
    wr(`REG_SEC, 8'h02);
    xtal(1);
    rd(`REG_SEC, 8'h02);
    wr(`REG_CS1, 8'h08);
    xtal(1);
    rd(`REG_SEC, 8'h03);
    wr(`REG_CS1, 8'h28);
    xtal(2);
    rd(`REG_SEC, 8'h03);
    wr(`REG_CS1, 8'h88);
    xtal(2);
    rd(`REG_SEC, 8'h03);
    // Halted while loading 23:59:58, Saturday
    wr(`REG_CS1, 8'h28);
    wr(`REG_SEC, 8'h58);
    wr(`REG_MIN, 8'h59);
    wr(`REG_HOUR, 8'h23);
    wr(`REG_DAY, 8'h23);
    wr(`REG_WDAY, 8'h06);
    wr(`REG_MONTH, 8'h87);
    wr(`REG_YEAR, 8'h12);
    // Only the minute field compared; disabled fields hold values that would miss
    wr(`REG_AMIN, 8'h00);
    wr(`REG_AHOUR, 8'h85);
    wr(`REG_ADAY, 8'h81);
    wr(`REG_AWDAY, 8'h83);
    wr(`REG_TCTL, 8'h80);
    wr(`REG_TVAL, 8'h01);
    wr(`REG_CS2, 8'h00);
    wr(`REG_CS1, 8'h08);
    xtal(2);
    rd(`REG_SEC, 8'h00);
    rd(`REG_HOUR, 8'h00);
    rd(`REG_DAY, 8'h24);
    rd(`REG_WDAY, 8'h00);
    rd(`REG_MONTH, 8'h87);
    rd(`REG_YEAR, 8'h12);
    rd(`REG_CS2, 8'h0C);
    chk({7'h00, irq_n}, 8'h01, "irq while disabled");
    wr(`REG_CS2, 8'h0E);
    chk({7'h00, irq_n}, 8'h00, "alarm irq");
    wr(`REG_CS2, 8'h06);
    chk({7'h00, irq_n}, 8'h01, "timer irq while disabled");
    wr(`REG_CS2, 8'h05);
    chk({7'h00, irq_n}, 8'h00, "timer irq");
    wr(`REG_CS2, 8'h00);
    chk({7'h00, irq_n}, 8'h01, "irq after clear");
    // Divided clock: crystal level first, then the divide-by-32 tap
    wr(`REG_DIVCLK, 8'h80);
    xtal_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({7'h00, div_out}, 8'h01, "crystal high on clock out");
    xtal_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({7'h00, div_out}, 8'h00, "crystal low on clock out");
    // Prescaler has counted five running edges so far; eleven more reach sixteen
    wr(`REG_DIVCLK, 8'h81);
    xtal(11);
    chk({7'h00, div_out}, 8'h01, "divide by 32 clock out");
    finish_test();
  end
endmodule // tb_rtc_register_setup
`default_nettype wire
